// [common/cfpe_pkg.sv]
// Shared constants and types of the CAN frame protocol engine
package cfpe_pkg;

	// Bus levels
	localparam logic DOMINANT = 1'b0;
	localparam logic RECESSIVE = 1'b1;

	// Field lengths in bits and last-bit indices
	localparam logic [6:0] ARB_LAST = 7'h0b;
	localparam logic [6:0] CTRL_LAST = 7'h05;
	localparam logic [6:0] CRC_LAST = 7'h0e;
	localparam logic [6:0] EOF_LAST = 7'h06;
	localparam logic [6:0] INTER_LAST = 7'h02;
	localparam logic [6:0] SUSP_LAST = 7'h07;
	localparam logic [6:0] FLAG_LAST = 7'h05;
	localparam logic [6:0] DELIM_LAST = 7'h06;
	localparam logic [6:0] DATA_MSB = 7'h3f;
	localparam logic [3:0] DLC_MAX = 4'h8;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [2:0] PFLAG_RUN = 3'h6;
	localparam logic [2:0] FLAG_EXT_MAX = 3'h6;
	localparam logic [1:0] OVL_MAX = 2'h2;

	// Protocol states, Gray coded along the frame path
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_SOF = 4'h1, ST_ARB = 4'h3, ST_CTRL = 4'h2,
		ST_DATA = 4'h6, ST_CRC = 4'h7, ST_CRCDEL = 4'h5, ST_ACK = 4'h4,
		ST_ACKDEL = 4'hc, ST_EOF = 4'hd, ST_INTER = 4'hf, ST_SUSP = 4'he,
		ST_FLAG = 4'ha, ST_FWAIT = 4'hb, ST_DELIM = 4'h9
	} cfpe_state_t;

	// Frame to send, held by the transmit buffer
	typedef struct packed {
		logic [10:0] id;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
		logic [14:0] crc;
	} cfpe_txfrm_t;

	// One-cycle event pulses and destuffed receive bit
	typedef struct packed {
		logic done;
		logic retry;
		logic lost;
		logic err;
		logic ovl;
		logic rx_vld;
		logic rx_bit;
		logic hsync;
	} cfpe_evt_t;

	// Engine state
	typedef struct packed {
		cfpe_state_t st;
		logic [6:0] cnt;
		logic [6:0] dlen;
		logic tx_bit;
		logic txing;
		logic stuff;
		logic pas;
		logic [1:0] ovl_cnt;
		logic was_tx;
		logic [2:0] dom_cnt;
		logic rx_rtr;
		logic [3:0] rx_dlc;
		cfpe_txfrm_t frm;
		cfpe_evt_t evt;
	} cfpe_eng_t;

	// Run-length tracker state
	typedef struct packed {
		logic last;
		logic [2:0] run;
	} cfpe_run_t;

	// Two-stage synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
	} cfpe_syn_t;

endpackage

// [sim/cfpe_peer.sv]
// Behavioural model of another CAN node sharing the serial bus
`timescale 1ns/100ps
`default_nettype none
module cfpe_peer
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sample_tick,
	input wire logic drive_dom,
	output logic peer_tx
);
	// ----------------------------------------------------------------
	// Bit driver
	// ----------------------------------------------------------------
	logic tx_ff;

	// Level changes only at a bit boundary, released to recessive otherwise
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tx_ff <= cfpe_pkg::RECESSIVE;
		else if (sample_tick)
			tx_ff <= drive_dom ? cfpe_pkg::DOMINANT : cfpe_pkg::RECESSIVE;
	end

	assign peer_tx = tx_ff;
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench of the CAN frame protocol engine
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin error_cnt++; \
	$display("ERROR %0t got %0h want %0h", $time, (act), (exp)); end end
module tb;
	// ----------------------------------------------------------------
	// Signals, clock and instances
	// ----------------------------------------------------------------
	logic clk, sys_rst, sample_tick, err_passive, tx_req, rx_crc_ok, pd_cmd;
	logic bus_tx, peer_tx, bus_idle, bus_rx, b, last_bit;
	cfpe_pkg::cfpe_txfrm_t tx_frm;
	cfpe_pkg::cfpe_evt_t evt, acc;
	int error_cnt, num_checks, run, len;
	logic exp_q[$];

	// Free-running clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Wired-AND bus, dominant wins
	assign bus_rx = bus_tx & peer_tx;

	cfpe_engine dut (.clk(clk), .sys_rst(sys_rst), .sample_tick(sample_tick), .bus_rx(bus_rx),
		.bus_tx(bus_tx), .err_passive(err_passive), .tx_req(tx_req), .tx_frm(tx_frm),
		.rx_crc_ok(rx_crc_ok), .evt(evt), .bus_idle(bus_idle));

	cfpe_peer peer (.clk(clk), .sys_rst(sys_rst), .sample_tick(sample_tick), .drive_dom(pd_cmd),
		.peer_tx(peer_tx));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One bit period: tick, then read the new bit and events
	task automatic step(input logic pd);
		pd_cmd = pd;
		sample_tick = 1'b1;
		@(negedge clk);
		sample_tick = 1'b0;
		b = bus_tx;
		acc = cfpe_pkg::cfpe_evt_t'(acc | evt);
		if (evt.done === 1'b1)
			tx_req = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	// Append one bit to the expected stream, stuffing after five equal
	task automatic put(input logic v);
		exp_q.push_back(v);
		run = (v === last_bit) ? run + 1 : 1;
		last_bit = v;
		if (run == 5)
		begin
			exp_q.push_back(~v);
			last_bit = ~v;
			run = 1;
		end
	endtask

	// Expected transmit stream of the current frame
	task automatic build();
		int nb;
		exp_q = {};
		run = 0;
		last_bit = 1'b1;
		put(1'b0);
		for (int k = 10; k >= 0; k--) put(tx_frm.id[k]);
		put(tx_frm.rtr);
		repeat (2) put(1'b0);
		for (int k = 3; k >= 0; k--) put(tx_frm.dlc[k]);
		nb = tx_frm.rtr ? 0 : (tx_frm.dlc > 4'h8 ? 64 : int'(tx_frm.dlc) * 8);
		for (int k = 0; k < nb; k++) put(tx_frm.data[63 - k]);
		for (int k = 14; k >= 0; k--) put(tx_frm.crc[k]);
		len = exp_q.size();
		repeat (10) exp_q.push_back(1'b1);
	endtask

	function automatic int first_one(input int lo);
		for (int i = lo; i < len; i++)
			if (exp_q[i] === 1'b1)
				return i;
		return lo;
	endfunction

	task automatic new_frame(input logic [10:0] id);
		tx_frm.id = id;
		tx_frm.rtr = 1'($urandom_range(1, 0));
		tx_frm.dlc = 4'($urandom_range(8, 0));
		tx_frm.data = {$urandom, $urandom};
		tx_frm.crc = 15'($urandom);
		tx_req = 1'b1;
		build();
	endtask

	// Wait for bus idle, then expect start of frame on the next bit
	task automatic sync_sof();
		int i;
		i = 0;
		while (bus_idle !== 1'b1 && i < 80)
		begin
			step(1'b0);
			i++;
		end
		step(1'b0);
		`CHK(b, cfpe_pkg::DOMINANT);
		acc = '0;
	endtask

	// Whole frame with peer acknowledge, then n provoked overloads
	task automatic frame(input int n);
		sync_sof();
		for (int i = 1; i < exp_q.size(); i++)
		begin
			step(i == len + 1);
			`CHK(b, exp_q[i]);
		end
		step(1'b0);
		`CHK(acc.done, 1'b1);
		`CHK(acc.err, 1'b0);
		if (n == 0)
		begin
			repeat (2) step(1'b0);
			`CHK(bus_idle, 1'b0);
			step(1'b0);
			`CHK(bus_idle, ~err_passive);
			repeat (8) step(1'b0);
			`CHK(bus_idle, 1'b1);
		end
		for (int j = 0; j < n; j++)
		begin
			step(1'b1);
			acc = '0;
			step(1'b0);
			`CHK(acc.ovl, 1'b1);
			for (int k = 0; k < 14; k++)
			begin
				`CHK(b, k < 6 ? cfpe_pkg::DOMINANT : cfpe_pkg::RECESSIVE);
				step(1'b0);
			end
			`CHK(acc.retry, 1'b0);
		end
		if (n > 0)
		begin
			step(1'b1);
			acc = '0;
			step(1'b0);
			`CHK(acc.ovl, 1'b0);
			`CHK(b, cfpe_pkg::RECESSIVE);
			repeat (7) step(1'b0);
			`CHK(acc.err, 1'b1);
		end
	endtask

	// Peer overrides bit idx dominant: arbitration loss or bit error
	task automatic disturb(input int idx, input logic lose);
		sync_sof();
		for (int i = 1; i <= idx; i++) step(i == idx);
		step(1'b0);
		if (lose)
		begin
			`CHK(acc.lost, 1'b1);
			`CHK(acc.err, 1'b0);
			repeat (4)
			begin
				`CHK(b, cfpe_pkg::RECESSIVE);
				step(1'b0);
			end
		end
		else
		begin
			`CHK(acc.retry, 1'b1);
			`CHK(acc.err, 1'b1);
			for (int k = 0; k < 14; k++)
			begin
				`CHK(b, (k < 6 && !err_passive) ? 1'b0 : 1'b1);
				step(1'b0);
			end
			`CHK(acc.err, 1'b1);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		sys_rst = 1'b1;
		sample_tick = 1'b0;
		err_passive = 1'b0;
		tx_req = 1'b0;
		rx_crc_ok = 1'b0;
		pd_cmd = 1'b0;
		tx_frm = '0;
		acc = '0;
		void'($urandom(95161));
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		`CHK(bus_tx, cfpe_pkg::RECESSIVE);
		`CHK(bus_idle, 1'b1);
		`CHK(evt, '0);
		new_frame(11'h000);
		tx_frm.rtr = 1'b0;
		tx_frm.dlc = 4'hf;
		tx_frm.data = '0;
		tx_frm.crc = '0;
		build();
		repeat (10) @(negedge clk);
		`CHK(bus_tx, cfpe_pkg::RECESSIVE);
		frame(0);
		new_frame(11'($urandom_range(2031, 0)));
		tx_frm.rtr = 1'b1;
		build();
		frame(0);
		for (int k = 0; k < 4; k++)
		begin
			err_passive = (k == 1);
			new_frame(11'($urandom_range(2031, 0)));
			frame(k == 3 ? 2 : 0);
		end
		for (int k = 0; k < 2; k++)
		begin
			err_passive = k[0];
			new_frame(11'($urandom_range(2031, 0)));
			tx_frm.crc = '1;
			build();
			disturb(first_one(16), 1'b0);
			frame(0);
		end
		err_passive = 1'b0;
		new_frame(11'($urandom_range(2031, 1024)));
		disturb(1, 1'b1);
		frame(0);
		end_of_test();
	end

	initial
	begin
		#8000000;
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire

// [src/cfpe_engine.sv]
// CAN frame protocol engine: framing, arbitration, stuffing, error and overload frames
//
// Notes on behaviour
// [RQ1] - Remote frames carry a recessive RTR bit, no data; receivers ignore their DLC.
// [RQ2] - Error-active node signals an error with six dominant flag bits.
// [RQ3] - Error-passive flag is recessive, complete after six equal bits from its start.
// [RQ4] - After the flag, wait for recessive then seven more recessive delimiter bits.
// [RQ5] - Superimposed flags of six to twelve dominant bits are accepted.
// [RQ6] - An error during own data or remote frame forces a retransmission.
// [RQ7] - Any deviation from the error frame shape starts a new error frame.
// [RQ8] - No receiver-not-ready overload; dominant in intermission starts overload next bit.
// [RQ9] - At most two overload frames before one data or remote frame.
// [RQ10] - Overload frames never cause retransmission of the previous frame.
// [RQ11] - Overload flag is six dominant bits, then an eight bit recessive delimiter.
// [RQ12] - Frames follow intermission and idle; passive senders add suspend transmission.
// [RQ13] - Intermission is three recessive bits with no frame start; after two overloads the code takes a dominant bit here as start of frame.
// [RQ14] - Transmit only from bus idle; dominant in idle is start of frame.
// [RQ15] - Recessive sent but dominant seen in arbitration: become receiver silently.
// [RQ16] - Identifier goes MSB first, RTR last; lowest value wins.
// [RQ17] - Software never loads identifiers whose top seven bits are all ones.
// [RQ18] - Sender inserts a complement bit after five equal bits, SOF through CRC.
// [RQ19] - Receiver drops the bit after five equal; not complement means stuff error.
// [RQ20] - Fixed-form fields are not stuffed; each bit holds its level all period.
// [RQ21] - Bit, stuff, form or ack error starts the flag in the next bit.
// [RQ22] - Error frame is overlapping flags followed by the delimiter.
// [RQ23] - CRC mismatch flags after the acknowledge delimiter unless already flagging.
// [RQ24] - All state moves only on the per-bit sample strobe; the evt pulses clear and the pin synchroniser shifts on every clock.
`timescale 1ns/100ps
`default_nettype none
module cfpe_engine
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sample_tick,
	input wire logic bus_rx,
	output logic bus_tx,
	input wire logic err_passive,
	input wire logic tx_req,
	input wire cfpe_pkg::cfpe_txfrm_t tx_frm,
	input wire logic rx_crc_ok,
	output var cfpe_pkg::cfpe_evt_t evt,
	output logic bus_idle
);
	cfpe_pkg::cfpe_eng_t q;
	cfpe_pkg::cfpe_eng_t nxt_q;
	logic rx_s;
	logic stf_hit;
	logic stf_last;
	logic pf_hit;
	logic stf_en;
	logic stf_rst;
	logic stuffed_st;

	//--------------------------------------------------------------
	// Pin input and run trackers
	//--------------------------------------------------------------

	cfpe_sync u_sync
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in(bus_rx),
		.pin_sync(rx_s)
	);

	// Stuffed region runs from SOF to the end of the CRC sequence
	assign stuffed_st = (q.st == cfpe_pkg::ST_SOF) || (q.st == cfpe_pkg::ST_ARB) ||
		(q.st == cfpe_pkg::ST_CTRL) || (q.st == cfpe_pkg::ST_DATA) ||
		(q.st == cfpe_pkg::ST_CRC);
	// A dominant bit in idle or suspend, or in intermission after two overloads, is a start of frame: restart the run there
	assign stf_en = sample_tick && (q.stuff || stuffed_st ||
		((q.st == cfpe_pkg::ST_IDLE || q.st == cfpe_pkg::ST_INTER ||
		q.st == cfpe_pkg::ST_SUSP) && rx_s == cfpe_pkg::DOMINANT)); // [RQ19]
	assign stf_rst = q.stuff || q.st == cfpe_pkg::ST_IDLE || q.st == cfpe_pkg::ST_SOF ||
		q.st == cfpe_pkg::ST_INTER || q.st == cfpe_pkg::ST_SUSP;

	cfpe_runlen #(.LIM(cfpe_pkg::STUFF_RUN)) u_stuff
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.en(stf_en),
		.restart(stf_rst),
		.bit_in(rx_s),
		.hit(stf_hit),
		.last_bit(stf_last)
	);

	// Equal-bit run counted from the start of a passive flag
	cfpe_runlen #(.LIM(cfpe_pkg::PFLAG_RUN)) u_pflag
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.en(sample_tick && q.st == cfpe_pkg::ST_FLAG),
		.restart(q.cnt == 7'h00),
		.bit_in(rx_s),
		.hit(pf_hit),
		.last_bit()
	);

	//--------------------------------------------------------------
	// Field bit selection for our own frame
	//--------------------------------------------------------------

	// Identifier MSB first then RTR, control, data MSB first, CRC MSB first
	function automatic logic fbit(input cfpe_pkg::cfpe_state_t s, input logic [6:0] c,
		input cfpe_pkg::cfpe_txfrm_t f);
		logic [11:0] arb;
		logic [5:0] ctl;
		arb = {f.id, f.rtr}; // [RQ16]
		ctl = {2'h0, f.dlc};
		case (s)
			cfpe_pkg::ST_SOF: fbit = cfpe_pkg::DOMINANT;
			cfpe_pkg::ST_ARB: fbit = arb[4'(cfpe_pkg::ARB_LAST - c)]; // [RQ16]
			cfpe_pkg::ST_CTRL: fbit = ctl[3'(cfpe_pkg::CTRL_LAST - c)];
			cfpe_pkg::ST_DATA: fbit = f.data[6'(cfpe_pkg::DATA_MSB - c)];
			cfpe_pkg::ST_CRC: fbit = f.crc[4'(cfpe_pkg::CRC_LAST - c)];
			default: fbit = cfpe_pkg::RECESSIVE; // [RQ20]
		endcase
	endfunction

	//--------------------------------------------------------------
	// Protocol state machine
	//--------------------------------------------------------------

	// Next state, evaluated at each sample point
	always_comb
	begin
		logic rxb;
		logic err;
		logic ovl;
		logic rtr;
		logic [3:0] dlc;
		rxb = rx_s;
		err = 1'b0;
		ovl = 1'b0;
		rtr = 1'b0;
		dlc = 4'h0;
		nxt_q = q;
		nxt_q.evt = '0;
		if (sample_tick) // [RQ24]
		begin
			// Own dominant overwritten, or own recessive lost outside arbitration and ack
			if (q.tx_bit == cfpe_pkg::DOMINANT && rxb == cfpe_pkg::RECESSIVE)
				err = 1'b1; // [RQ7]
			else if (q.txing && q.tx_bit == cfpe_pkg::RECESSIVE &&
				rxb == cfpe_pkg::DOMINANT && q.st != cfpe_pkg::ST_ACK)
			begin
				if (q.st == cfpe_pkg::ST_ARB && !q.stuff)
				begin
					nxt_q.txing = 1'b0; // [RQ15]
					nxt_q.evt.lost = 1'b1;
				end
				else
					err = 1'b1;
			end
			if (err)
			begin
			end
			else if (q.stuff)
			begin
				// Sampled bit is a stuff bit: dropped, must be the complement
				nxt_q.stuff = 1'b0;
				if (rxb == stf_last)
					err = 1'b1; // [RQ19]
			end
			else
			begin
				if (stuffed_st)
				begin
					nxt_q.evt.rx_vld = 1'b1;
					nxt_q.evt.rx_bit = rxb;
				end
				nxt_q.cnt = q.cnt + 7'h01;
				case (q.st)
					cfpe_pkg::ST_IDLE:
					begin
						nxt_q.cnt = 7'h00;
						nxt_q.ovl_cnt = 2'h0;
						if (rxb == cfpe_pkg::DOMINANT)
						begin
							nxt_q.st = cfpe_pkg::ST_ARB; // [RQ14]
							nxt_q.evt.hsync = 1'b1;
							nxt_q.evt.rx_vld = 1'b1;
							nxt_q.was_tx = 1'b0;
						end
						else if (tx_req)
						begin
							nxt_q.st = cfpe_pkg::ST_SOF; // [RQ14]
							nxt_q.txing = 1'b1;
							nxt_q.was_tx = 1'b1;
							nxt_q.frm = tx_frm;
						end
					end
					cfpe_pkg::ST_SOF:
					begin
						nxt_q.st = cfpe_pkg::ST_ARB;
						nxt_q.cnt = 7'h00;
					end
					cfpe_pkg::ST_ARB:
					begin
						if (q.cnt == cfpe_pkg::ARB_LAST)
						begin
							nxt_q.rx_rtr = rxb;
							nxt_q.st = cfpe_pkg::ST_CTRL;
							nxt_q.cnt = 7'h00;
						end
					end
					cfpe_pkg::ST_CTRL:
					begin
						nxt_q.rx_dlc = {q.rx_dlc[2:0], rxb};
						if (q.cnt == cfpe_pkg::CTRL_LAST)
						begin
							// Remote frames have no data whatever their length code
							rtr = q.txing ? q.frm.rtr : q.rx_rtr; // [RQ1]
							dlc = q.txing ? q.frm.dlc : {q.rx_dlc[2:0], rxb};
							if (dlc > cfpe_pkg::DLC_MAX)
								dlc = cfpe_pkg::DLC_MAX;
							nxt_q.dlen = rtr ? 7'h00 : {dlc, 3'h0};
							nxt_q.st = (rtr || dlc == 4'h0) ? cfpe_pkg::ST_CRC : cfpe_pkg::ST_DATA;
							nxt_q.cnt = 7'h00;
						end
					end
					cfpe_pkg::ST_DATA:
					begin
						if (q.cnt == q.dlen - 7'h01)
						begin
							nxt_q.st = cfpe_pkg::ST_CRC;
							nxt_q.cnt = 7'h00;
						end
					end
					cfpe_pkg::ST_CRC:
					begin
						if (q.cnt == cfpe_pkg::CRC_LAST)
							nxt_q.st = cfpe_pkg::ST_CRCDEL;
					end
					cfpe_pkg::ST_CRCDEL:
					begin
						err = (rxb == cfpe_pkg::DOMINANT);
						nxt_q.st = cfpe_pkg::ST_ACK;
					end
					cfpe_pkg::ST_ACK:
					begin
						err = q.txing && rxb == cfpe_pkg::RECESSIVE; // [RQ21]
						nxt_q.st = cfpe_pkg::ST_ACKDEL;
					end
					cfpe_pkg::ST_ACKDEL:
					begin
						err = (rxb == cfpe_pkg::DOMINANT) || (!q.txing && !rx_crc_ok); // [RQ23]
						nxt_q.st = cfpe_pkg::ST_EOF;
						nxt_q.cnt = 7'h00;
					end
					cfpe_pkg::ST_EOF:
					begin
						err = (rxb == cfpe_pkg::DOMINANT);
						if (q.cnt == cfpe_pkg::EOF_LAST)
						begin
							nxt_q.evt.done = q.txing;
							nxt_q.txing = 1'b0;
							nxt_q.st = cfpe_pkg::ST_INTER;
							nxt_q.cnt = 7'h00;
						end
					end
					cfpe_pkg::ST_INTER:
					begin
						// Dominant here requests an overload flag from the next bit, or starts a frame after two overloads
						if (rxb == cfpe_pkg::DOMINANT)
						begin
							if (q.ovl_cnt < cfpe_pkg::OVL_MAX)
								ovl = 1'b1; // [RQ8] [RQ9]
							else
							begin
								nxt_q.st = cfpe_pkg::ST_ARB;
								nxt_q.cnt = 7'h00;
								nxt_q.ovl_cnt = 2'h0;
								nxt_q.was_tx = 1'b0;
							end
						end
						else if (q.cnt == cfpe_pkg::INTER_LAST) // [RQ13]
						begin
							nxt_q.cnt = 7'h00;
							nxt_q.st = (err_passive && q.was_tx) ?
								cfpe_pkg::ST_SUSP : cfpe_pkg::ST_IDLE; // [RQ12]
						end
					end
					cfpe_pkg::ST_SUSP:
					begin
						if (rxb == cfpe_pkg::DOMINANT)
						begin
							nxt_q.st = cfpe_pkg::ST_ARB;
							nxt_q.cnt = 7'h00;
							nxt_q.evt.hsync = 1'b1;
							nxt_q.was_tx = 1'b0;
						end
						else if (q.cnt == cfpe_pkg::SUSP_LAST)
							nxt_q.st = cfpe_pkg::ST_IDLE;
					end
					cfpe_pkg::ST_FLAG:
					begin
						// Active flag ends after six bits, passive after six equal bits
						if (q.pas ? pf_hit : q.cnt == cfpe_pkg::FLAG_LAST) // [RQ2] [RQ3]
						begin
							nxt_q.st = cfpe_pkg::ST_FWAIT;
							nxt_q.dom_cnt = 3'h0;
						end
						else if (q.cnt == 7'h7f)
							nxt_q.cnt = q.cnt;
					end
					cfpe_pkg::ST_FWAIT:
					begin
						// Wait for the recessive edge; it is the delimiter's first bit
						if (rxb == cfpe_pkg::RECESSIVE)
						begin
							nxt_q.st = cfpe_pkg::ST_DELIM; // [RQ4] [RQ11] [RQ22]
							nxt_q.cnt = 7'h00;
						end
						else if (q.dom_cnt == cfpe_pkg::FLAG_EXT_MAX)
							err = 1'b1; // [RQ5] [RQ7]
						else
							nxt_q.dom_cnt = q.dom_cnt + 3'h1;
					end
					cfpe_pkg::ST_DELIM:
					begin
						err = (rxb == cfpe_pkg::DOMINANT); // [RQ7]
						if (q.cnt == cfpe_pkg::DELIM_LAST)
						begin
							nxt_q.st = cfpe_pkg::ST_INTER;
							nxt_q.cnt = 7'h00;
						end
					end
					default:
					begin
						nxt_q.st = cfpe_pkg::ST_IDLE;
						nxt_q.cnt = 7'h00;
					end
				endcase
				// Five equal bits in the stuffed region: next bit is a stuff bit
				if (stf_hit && !err && !ovl)
					nxt_q.stuff = 1'b1; // [RQ18] [RQ19]
			end
			// Error or overload flag starts with the next bit
			if (err || ovl)
			begin
				nxt_q.st = cfpe_pkg::ST_FLAG; // [RQ21]
				nxt_q.cnt = 7'h00;
				nxt_q.stuff = 1'b0;
				nxt_q.txing = 1'b0;
				nxt_q.pas = err && err_passive;
				nxt_q.evt.err = err;
				nxt_q.evt.ovl = !err;
				nxt_q.evt.lost = 1'b0;
				nxt_q.evt.retry = err && q.txing; // [RQ6] [RQ10]
				nxt_q.was_tx = q.was_tx && !err || q.txing;
				nxt_q.ovl_cnt = err ? 2'h0 : q.ovl_cnt + 2'h1; // [RQ9]
			end
			// Level driven for the whole next bit period
			if (nxt_q.st == cfpe_pkg::ST_FLAG)
				nxt_q.tx_bit = nxt_q.pas ? cfpe_pkg::RECESSIVE : cfpe_pkg::DOMINANT; // [RQ2]
			else if (nxt_q.stuff)
				nxt_q.tx_bit = nxt_q.txing ? ~rxb : cfpe_pkg::RECESSIVE; // [RQ18]
			else if (nxt_q.txing)
				nxt_q.tx_bit = fbit(nxt_q.st, nxt_q.cnt, nxt_q.frm); // [RQ20]
			else if (nxt_q.st == cfpe_pkg::ST_ACK && rx_crc_ok)
				nxt_q.tx_bit = cfpe_pkg::DOMINANT;
			else
				nxt_q.tx_bit = cfpe_pkg::RECESSIVE; // [RQ15]
		end
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= '0;
			q.tx_bit <= cfpe_pkg::RECESSIVE;
		end
		else
			q <= nxt_q;
	end

	assign bus_tx = q.tx_bit;
	assign evt = q.evt;
	assign bus_idle = (q.st == cfpe_pkg::ST_IDLE);

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_inter_dom;
		sample_tick && q.st == cfpe_pkg::ST_INTER && rx_s == cfpe_pkg::DOMINANT;
	endsequence

	sequence s_flag_start;
		q.st == cfpe_pkg::ST_FLAG && q.cnt == 7'h00;
	endsequence

	tick_only_a: assert property (!sample_tick |=> $stable(q.st)) // [RQ24]
		else $error("state moved without a sample strobe");
	active_flag_a: assert property ((q.st == cfpe_pkg::ST_FLAG && !q.pas) |->
		bus_tx == cfpe_pkg::DOMINANT) // [RQ2]
		else $error("active flag bit not dominant");
	passive_flag_a: assert property ((q.st == cfpe_pkg::ST_FLAG && q.pas) |->
		bus_tx == cfpe_pkg::RECESSIVE) // [RQ3]
		else $error("passive flag bit not recessive");
	delim_level_a: assert property (q.st == cfpe_pkg::ST_DELIM |->
		bus_tx == cfpe_pkg::RECESSIVE) // [RQ4]
		else $error("delimiter bit not recessive");
	err_start_a: assert property (evt.err |-> s_flag_start) // [RQ21]
		else $error("error flag did not start next bit");
	ovl_start_a: assert property (s_inter_dom ##0 (q.ovl_cnt < cfpe_pkg::OVL_MAX) |=>
		s_flag_start ##0 evt.ovl && !q.pas) // [RQ8]
		else $error("overload flag not started after dominant intermission");
	ovl_limit_a: assert property (q.ovl_cnt <= cfpe_pkg::OVL_MAX) // [RQ9]
		else $error("too many overload frames");
	ovl_retry_a: assert property (evt.ovl |-> !evt.retry) // [RQ10]
		else $error("overload frame caused retry");
	inter_quiet_a: assert property (q.st == cfpe_pkg::ST_INTER |->
		!q.txing && bus_tx == cfpe_pkg::RECESSIVE) // [RQ13]
		else $error("frame started during intermission");
	start_idle_a: assert property ($rose(q.txing) |-> $past(q.st) == cfpe_pkg::ST_IDLE) // [RQ14]
		else $error("transmission started outside idle");
	arb_lost_a: assert property (evt.lost |-> !q.txing && bus_tx == cfpe_pkg::RECESSIVE) // [RQ15]
		else $error("sender kept driving after losing arbitration");
	stuff_bit_a: assert property ((q.stuff && q.txing) |-> bus_tx != stf_last) // [RQ18]
		else $error("stuff bit not complement");
	remote_nodata_a: assert property ((q.txing && q.frm.rtr) |-> q.st != cfpe_pkg::ST_DATA) // [RQ1]
		else $error("remote frame sent a data field");
	retry_err_a: assert property (evt.retry |-> evt.err && $past(q.txing)) // [RQ6]
		else $error("retry without error during own frame");
endmodule
`default_nettype wire

// [src/cfpe_runlen.sv]
// Counter of consecutive equal bus bits with early limit detect
`timescale 1ns/100ps
`default_nettype none
module cfpe_runlen
#(
	parameter logic [2:0] LIM = 3'h5
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic en,
	input wire logic restart,
	input wire logic bit_in,
	output logic hit,
	output logic last_bit
);
	cfpe_pkg::cfpe_run_t q;
	cfpe_pkg::cfpe_run_t nxt_q;

	// Hit flags the bit that completes a run of LIM equal bits
	assign hit = en && !restart && (bit_in == q.last) && (q.run == LIM - 3'h1);
	assign last_bit = q.last;

	// Start a new run or extend the current one, saturating
	always_comb
	begin
		nxt_q = q;
		if (en)
		begin
			nxt_q.last = bit_in;
			if (restart || bit_in != q.last)
				nxt_q.run = 3'h1;
			else if (q.run != 3'h7)
				nxt_q.run = q.run + 3'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= nxt_q;
	end
endmodule
`default_nettype wire

// [src/cfpe_sync.sv]
// Two-stage synchroniser for the bus receive pin
`timescale 1ns/100ps
`default_nettype none
module cfpe_sync
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic pin_sync
);
	cfpe_pkg::cfpe_syn_t q;
	cfpe_pkg::cfpe_syn_t nxt_q;

	// Shift the pin through two stages
	always_comb
	begin
		nxt_q.s1 = pin_in;
		nxt_q.s2 = q.s1;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			q <= 2'h3;
		else
			q <= nxt_q;
	end

	assign pin_sync = q.s2;
endmodule
`default_nettype wire
